// ---- core/rmw_watchdog.sv ----
// Runaway monitor watchdog with register port and interrupt logic.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module rmw_watchdog
	import rmw_pkg::*;
#(
	parameter int PERIOD_BASE_EXP = PERIOD_EXP_BASE
)(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [REG_ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	input wire logic idleMode,
	input wire logic debugMode,
	output logic runawayIrq,
	output logic nmiSource0Flag,
	output logic runawayAlertN,
	output logic ctrlResetOut,
	output logic clockSetupInit,
	output logic irqOut
);

	localparam int CNT_W = PERIOD_BASE_EXP + PERIOD_EXP_SPAN;

	// ****************************************************************
	// Address decode.
	// ****************************************************************
	function automatic logic isAt(
		input logic [REG_ADDR_W-1:0] a,
		input logic [REG_ADDR_W-1:0] ofs
	);
		isAt = (a == ofs);
	endfunction : isAt

	logic wrMode;
	logic wrCmd;
	logic wrClr;
	logic wrIen;

	assign wrMode = regWr && isAt(regAddr, MODE_OFS);
	assign wrCmd = regWr && isAt(regAddr, CMD_OFS);
	assign wrClr = regWr && isAt(regAddr, CLR_OFS);
	assign wrIen = regWr && isAt(regAddr, IEN_OFS);

	// ****************************************************************
	// Declarations.
	// ****************************************************************
	rmw_state_type state_r;
	rmw_state_type state_nxt;
	logic modeEn_r;
	logic [2:0] modePer_r;
	logic modeIdle_r;
	logic modeAct_r;
	logic modeRsv_r;
	logic [RESET_CNT_W-1:0] rstCnt_r;
	logic [EV_W-1:0] evStat_r;
	logic [EV_W-1:0] evStat_nxt;
	logic [EV_W-1:0] evEn_r;
	logic [EV_W-1:0] evEn_nxt;
	logic [EV_W-1:0] evSet;
	logic [EV_W-1:0] evClr;
	logic [31:0] rdMux;
	logic [CNT_W-1:0] count;
	logic overflow;
	logic cntRun;
	logic cntClear;
	logic cmdClear;
	logic cmdDisable;
	logic cmdBad;
	logic modeWrOk;
	logic perBad;
	logic nmiEvent;
	logic enterSysRst;
	logic [2:0] wrPer;

	// ****************************************************************
	// Command decode.
	// ****************************************************************
	assign cmdClear = wrCmd && (regWrData[7:0] == CMD_CLEAR);
	assign cmdDisable = wrCmd && (regWrData[7:0] == CMD_DISABLE)
		&& !modeEn_r;
	assign cmdBad = wrCmd && (regWrData[7:0] != CMD_CLEAR)
		&& (regWrData[7:0] != CMD_DISABLE);

	assign modeWrOk = wrMode && (state_r != ST_SYSRST);
	assign wrPer = regWrData[MODE_PER_MSB:MODE_PER_LSB];
	assign perBad = modeWrOk && (wrPer > PER_MAX_LEGAL);

	// ****************************************************************
	// Counter control.
	// ****************************************************************
	assign cntRun = (state_r == ST_RUN)
		&& !debugMode
		&& !(idleMode && !modeIdle_r);
	assign cntClear = cmdClear || (state_r != ST_RUN);

	rmw_counter #(
		.BASE_EXP(PERIOD_BASE_EXP),
		.CNT_W(CNT_W)
	) u_counter (
		.core_clk(core_clk),
		.rst(rst),
		.clear(cntClear),
		.run(cntRun),
		.periodSel(modePer_r),
		.overflow(overflow),
		.count(count)
	);

	assign nmiEvent = overflow && !modeAct_r;
	assign enterSysRst = overflow && modeAct_r;

	// ****************************************************************
	// State machine.
	// ****************************************************************
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_RUN: begin
				if (enterSysRst) begin
					state_nxt = ST_SYSRST;
				end else if (cmdDisable) begin
					state_nxt = ST_OFF;
				end
			end
			ST_OFF: begin
				if (wrMode && regWrData[MODE_EN_BIT]) begin
					state_nxt = ST_RUN;
				end
			end
			ST_SYSRST: begin
				if (rstCnt_r == RESET_CNT_W'(RESET_STATES - 1)) begin
					state_nxt = ST_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rstCnt_r <= '0;
		end else if (state_r == ST_SYSRST) begin
			rstCnt_r <= rstCnt_r + 1'b1;
		end else begin
			rstCnt_r <= '0;
		end
	end

	// ****************************************************************
	// Mode register.
	// ****************************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			modeEn_r <= MODE_EN_RST;
			modePer_r <= MODE_PER_RST;
			modeIdle_r <= MODE_IDLE_RST;
			modeAct_r <= MODE_ACT_RST;
			modeRsv_r <= MODE_RSV_RST;
		end else if (enterSysRst) begin
			modeEn_r <= MODE_EN_RST;
			modePer_r <= MODE_PER_RST;
			modeIdle_r <= MODE_IDLE_RST;
			modeAct_r <= MODE_ACT_RST;
			modeRsv_r <= MODE_RSV_RST;
		end else if (modeWrOk) begin
			modeEn_r <= regWrData[MODE_EN_BIT];
			if (!perBad) begin
				modePer_r <= wrPer;
			end
			modeIdle_r <= regWrData[MODE_IDLE_BIT];
			modeAct_r <= regWrData[MODE_ACT_BIT];
			modeRsv_r <= regWrData[MODE_RSV_BIT];
		end
	end

	// ****************************************************************
	// Reset request and clock setup outputs.
	// ****************************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrlResetOut <= 1'b0;
		end else begin
			ctrlResetOut <= (state_nxt == ST_SYSRST);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			clockSetupInit <= 1'b0;
		end else begin
			clockSetupInit <= enterSysRst;
		end
	end

	// ****************************************************************
	// NMI request and alert output.
	// ****************************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			runawayIrq <= 1'b0;
		end else begin
			runawayIrq <= nmiEvent;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			runawayAlertN <= 1'b1;
		end else if (nmiEvent) begin
			runawayAlertN <= 1'b0;
		end else if (cmdClear || enterSysRst) begin
			runawayAlertN <= 1'b1;
		end
	end

	// ****************************************************************
	// Event status, enable and interrupt output.
	// ****************************************************************
	always_comb begin
		evSet = '0;
		evSet[EV_NMI_BIT] = nmiEvent;
		evSet[EV_RESET_BIT] = enterSysRst;
		evSet[EV_BADCMD_BIT] = cmdBad;
		evSet[EV_BADPER_BIT] = perBad;
	end

	assign evClr = wrClr ? regWrData[EV_W-1:0] : '0;
	assign evStat_nxt = (evStat_r & ~evClr) | evSet;
	assign evEn_nxt = wrIen ? regWrData[EV_W-1:0] : evEn_r;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			evStat_r <= EV_RST;
		end else begin
			evStat_r <= evStat_nxt;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			evEn_r <= EV_RST;
		end else begin
			evEn_r <= evEn_nxt;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			nmiSource0Flag <= 1'b0;
		end else begin
			nmiSource0Flag <= evStat_nxt[EV_NMI_BIT];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irqOut <= 1'b0;
		end else begin
			irqOut <= |(evStat_nxt & evEn_nxt);
		end
	end

	// ****************************************************************
	// Read port.
	// ****************************************************************
	always_comb begin
		rdMux = '0;
		if (isAt(regAddr, MODE_OFS)) begin
			rdMux[MODE_EN_BIT] = modeEn_r;
			rdMux[MODE_PER_MSB:MODE_PER_LSB] = modePer_r;
			rdMux[MODE_IDLE_BIT] = modeIdle_r;
			rdMux[MODE_ACT_BIT] = modeAct_r;
			rdMux[MODE_RSV_BIT] = modeRsv_r;
		end else if (isAt(regAddr, STAT_OFS)) begin
			rdMux[EV_W-1:0] = evStat_r;
		end else if (isAt(regAddr, IEN_OFS)) begin
			rdMux[EV_W-1:0] = evEn_r;
		end else if (isAt(regAddr, STATE_OFS)) begin
			rdMux[0] = (state_r == ST_RUN);
			rdMux[1] = (state_r == ST_OFF);
			rdMux[2] = (state_r == ST_SYSRST);
			rdMux[3] = cntRun;
		end else if (isAt(regAddr, COUNT_OFS)) begin
			rdMux[CNT_W-1:0] = count;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			regRdData <= '0;
		end else if (regRd) begin
			regRdData <= rdMux;
		end else begin
			regRdData <= '0;
		end
	end

endmodule : rmw_watchdog

// ---- common/rmw_pkg.sv ----
// Constants, register map and types shared by the runaway monitor.
package rmw_pkg;

	// ****************************************************************
	// Register bus and offsets.
	// ****************************************************************
	localparam int REG_ADDR_W = 8;
	localparam logic [7:0] MODE_OFS = 8'h00;
	localparam logic [7:0] CMD_OFS = 8'h04;
	localparam logic [7:0] STAT_OFS = 8'h08;
	localparam logic [7:0] CLR_OFS = 8'h0C;
	localparam logic [7:0] IEN_OFS = 8'h10;
	localparam logic [7:0] STATE_OFS = 8'h14;
	localparam logic [7:0] COUNT_OFS = 8'h18;

	// ****************************************************************
	// Mode register fields and reset values.
	// ****************************************************************
	localparam int MODE_EN_BIT = 7;
	localparam int MODE_PER_MSB = 6;
	localparam int MODE_PER_LSB = 4;
	localparam int MODE_IDLE_BIT = 2;
	localparam int MODE_ACT_BIT = 1;
	localparam int MODE_RSV_BIT = 0;
	localparam logic MODE_EN_RST = 1'b1;
	localparam logic [2:0] MODE_PER_RST = 3'h0;
	localparam logic MODE_IDLE_RST = 1'b0;
	localparam logic MODE_ACT_RST = 1'b1;
	localparam logic MODE_RSV_RST = 1'b0;
	localparam logic [2:0] PER_MAX_LEGAL = 3'h5;

	// ****************************************************************
	// Command codes.
	// ****************************************************************
	localparam logic [7:0] CMD_DISABLE = 8'hB1;
	localparam logic [7:0] CMD_CLEAR = 8'h4E;

	// ****************************************************************
	// Event status bits.
	// ****************************************************************
	localparam int EV_W = 4;
	localparam int EV_NMI_BIT = 0;
	localparam int EV_RESET_BIT = 1;
	localparam int EV_BADCMD_BIT = 2;
	localparam int EV_BADPER_BIT = 3;
	localparam logic [EV_W-1:0] EV_RST = 4'h0;

	// ****************************************************************
	// Timing.
	// ****************************************************************
	localparam int PERIOD_EXP_BASE = 15;
	localparam int PERIOD_EXP_STEP = 2;
	localparam int PERIOD_EXP_SPAN = 10;
	localparam int RESET_STATES = 32;
	localparam int RESET_CNT_W = 6;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_OFF,
		ST_SYSRST
	} rmw_state_type;

endpackage : rmw_pkg

// ---- core/rmw_counter.sv ----
// Binary overflow counter with selectable period.
`timescale 1ns/1ps
module rmw_counter
	import rmw_pkg::*;
#(
	parameter int BASE_EXP = PERIOD_EXP_BASE,
	parameter int CNT_W = BASE_EXP + PERIOD_EXP_SPAN
)(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic run,
	input wire logic [2:0] periodSel,
	output logic overflow,
	output logic [CNT_W-1:0] count
);

	// ****************************************************************
	// Terminal count for a period code.
	// ****************************************************************
	function automatic logic [CNT_W-1:0] termOf(input logic [2:0] sel);
		int e;
		e = BASE_EXP + PERIOD_EXP_STEP * int'(sel);
		termOf = {CNT_W{1'b1}} >> (CNT_W - e);
	endfunction : termOf

	logic hitTerm;

	assign hitTerm = run && (count >= termOf(periodSel));
	assign overflow = hitTerm;

	// ****************************************************************
	// Counter.
	// ****************************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else if (clear || hitTerm) begin
			count <= '0;
		end else if (run) begin
			count <= count + 1'b1;
		end
	end

endmodule : rmw_counter

// ---- tb/rmw_watchdog_properties.sv ----
// Port checks for the runaway monitor.
`timescale 1ns/1ps
module rmw_watchdog_props
	import rmw_pkg::*;
#(
	parameter int PERIOD_BASE_EXP = PERIOD_EXP_BASE
)(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [REG_ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [31:0] regRdData,
	input wire logic idleMode,
	input wire logic debugMode,
	input wire logic runawayIrq,
	input wire logic nmiSource0Flag,
	input wire logic runawayAlertN,
	input wire logic ctrlResetOut,
	input wire logic clockSetupInit,
	input wire logic irqOut
);
	logic [5:0] rstLen_r;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// ********
	// Length of the internal reset.
	// ********
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rstLen_r <= 6'h0;
		end else if (ctrlResetOut) begin
			rstLen_r <= rstLen_r + 6'h1;
		end else begin
			rstLen_r <= 6'h0;
		end
	end
	a_reset_len_max: assert property (
		ctrlResetOut |-> rstLen_r < 6'h20)
		else $error("internal reset too long");
	a_reset_len_exact: assert property (
		$fell(ctrlResetOut) |-> rstLen_r == 6'h20)
		else $error("internal reset not 32 cycles");
	a_init_first: assert property (
		clockSetupInit |-> ctrlResetOut && rstLen_r == 6'h0)
		else $error("clock init outside first reset cycle");
	a_init_on_rise: assert property (
		$rose(ctrlResetOut) |-> clockSetupInit)
		else $error("clock init missing");
	a_irq_pulse: assert property (
		runawayIrq |=> !runawayIrq)
		else $error("interrupt not one cycle");
	a_alert_with_irq: assert property (
		runawayIrq |-> !runawayAlertN)
		else $error("alert not low with interrupt");
	a_alert_fall_cause: assert property (
		$fell(runawayAlertN) |-> runawayIrq)
		else $error("alert fell without interrupt");
	a_alert_clear: assert property (
		regWr && regAddr == CMD_OFS && regWrData[7:0] == CMD_CLEAR
		|=> runawayAlertN || runawayIrq)
		else $error("alert not released by clear");
	a_flag_follows: assert property (
		runawayIrq |-> ##[0:1] nmiSource0Flag)
		else $error("source flag not set");
	a_read_idle: assert property (
		!regRd |=> regRdData == 32'h0000_0000)
		else $error("read data without read");
	a_mode_spare: assert property (
		regRd && regAddr == MODE_OFS
		|=> regRdData[31:8] == 24'h00_0000 && !regRdData[3])
		else $error("mode spare bits not zero");
	cover property ($rose(ctrlResetOut));
	cover property (runawayIrq);
	cover property ($rose(irqOut));
endmodule : rmw_watchdog_props

bind rmw_watchdog rmw_watchdog_props #(
	.PERIOD_BASE_EXP(PERIOD_BASE_EXP)
) u_props (
	.core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
	.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .idleMode(idleMode),
	.debugMode(debugMode), .runawayIrq(runawayIrq),
	.nmiSource0Flag(nmiSource0Flag), .runawayAlertN(runawayAlertN),
	.ctrlResetOut(ctrlResetOut), .clockSetupInit(clockSetupInit),
	.irqOut(irqOut));

// ---- tb/testbench.sv ----
// Self-checking bench for the runaway monitor.
`timescale 1ns/1ps
module testbench import rmw_pkg::*;;
	localparam int BASE = 4;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0000_0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic idleMode = 1'b0;
	logic debugMode = 1'b0;
	logic [31:0] regRdData;
	logic runawayIrq, nmiSource0Flag, runawayAlertN;
	logic ctrlResetOut, clockSetupInit, irqOut;
	int nIrq = 0;
	int nRst = 0;
	int n_mismatch = 0;
	int checks = 0;
	int cyc = 0;
	int n;
	always #5 core_clk = ~core_clk;
	rmw_watchdog #(.PERIOD_BASE_EXP(BASE)) dut (.core_clk(core_clk),
		.rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .idleMode(idleMode),
		.debugMode(debugMode), .runawayIrq(runawayIrq),
		.nmiSource0Flag(nmiSource0Flag), .runawayAlertN(runawayAlertN),
		.ctrlResetOut(ctrlResetOut), .clockSetupInit(clockSetupInit),
		.irqOut(irqOut));
	// ********
	// Tasks.
	// ********
	task automatic end_sim();
		$display("Mismatches %0d of %0d checks", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic near(input string nm, input int e, input int g);
		checks++;
		if (g < e - 1 || g > e + 2) begin
			n_mismatch++;
			$display("Error %s expected %0d seen %0d", nm, e, g);
		end
	endtask : near
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge core_clk);
		regWr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e, input string nm);
		@(posedge core_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge core_clk);
		regRd <= 1'b0;
		#1;
		chk(nm, e, regRdData & m);
	endtask : rd
	task automatic waitLvl(input logic sel, input logic v, output int c);
		c = 0;
		while ((sel ? ctrlResetOut : runawayIrq) !== v && c < 20000) begin
			@(posedge core_clk);
			#1;
			c++;
		end
	endtask : waitLvl
	task automatic quiet(input int k);
		int i0;
		int r0;
		i0 = nIrq;
		r0 = nRst;
		repeat (k) @(posedge core_clk);
		#1;
		chk("quiet", 32'h0, 32'(nIrq - i0 + nRst - r0));
	endtask : quiet
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (runawayIrq === 1'b1) begin
			nIrq <= nIrq + 1;
		end
		if (ctrlResetOut === 1'b1) begin
			nRst <= nRst + 1;
		end
	end
	// ********
	// Scenarios.
	// ********
	task automatic run_tests();
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		rd(MODE_OFS, 32'hFFFF_FFFF, 32'h0000_0082, "mode");
		wr(MODE_OFS, 32'h0000_0086);
		waitLvl(1'b1, 1'b1, n);
		near("firstreset", 12, n);
		chk("clkinit", 32'h1, 32'(clockSetupInit));
		waitLvl(1'b1, 1'b0, n);
		chk("resetlen", 32'd32, 32'(n));
		rd(MODE_OFS, 32'hFF, 32'h0000_0082, "reload");
		wr(CMD_OFS, {24'h00_0000, CMD_DISABLE});
		rd(STATE_OFS, 32'h2, 32'h0, "notoff");
		wr(MODE_OFS, 32'h0000_0002);
		wr(CMD_OFS, {24'h00_0000, CMD_DISABLE});
		rd(STATE_OFS, 32'h2, 32'h2, "off");
		quiet(100);
		rd(COUNT_OFS, 32'hFFFF_FFFF, 32'h0, "count");
		for (int k = 0; k <= 5; k++) begin
			wr(MODE_OFS, {24'h00_0000, 1'b1, 3'(k), 4'h0});
			wr(CMD_OFS, {24'h00_0000, CMD_CLEAR});
			chk("alerthigh", 32'h1, 32'(runawayAlertN));
			waitLvl(1'b0, 1'b1, n);
			near("period", 1 << (BASE + 2 * k), n);
			chk("alertlow", 32'h0, 32'(runawayAlertN));
		end
		rd(STAT_OFS, 32'h3, 32'h3, "stat");
		chk("nmiflag", 32'h1, 32'(nmiSource0Flag));
		wr(IEN_OFS, 32'h0000_0001);
		chk("irqon", 32'h1, 32'(irqOut));
		wr(IEN_OFS, 32'h0000_0000);
		chk("irqmask", 32'h0, 32'(irqOut));
		wr(IEN_OFS, 32'h0000_0001);
		wr(CLR_OFS, 32'h0000_0001);
		chk("irqclr", 32'h0, 32'({irqOut, nmiSource0Flag}));
		wr(MODE_OFS, 32'h0000_00E0);
		rd(MODE_OFS, 32'hFF, 32'h0000_00D0, "badper");
		wr(CMD_OFS, 32'h0000_0012);
		rd(STAT_OFS, 32'hC, 32'hC, "reject");
		rd(CMD_OFS, 32'hFFFF_FFFF, 32'h0, "cmdread");
		rd(8'h40, 32'hFFFF_FFFF, 32'h0, "unmapped");
		@(posedge core_clk);
		idleMode <= 1'b1;
		wr(MODE_OFS, 32'h0000_0080);
		wr(CMD_OFS, {24'h00_0000, CMD_CLEAR});
		quiet(40);
		wr(MODE_OFS, 32'h0000_0084);
		waitLvl(1'b0, 1'b1, n);
		chk("idlerun", 32'h1, 32'(n < 20));
		@(posedge core_clk);
		idleMode <= 1'b0;
		debugMode <= 1'b1;
		wr(CMD_OFS, {24'h00_0000, CMD_CLEAR});
		quiet(40);
		@(posedge core_clk);
		debugMode <= 1'b0;
		waitLvl(1'b0, 1'b1, n);
		chk("resume", 32'h1, 32'(n < 20));
	endtask : run_tests
	initial begin
		fork
			run_tests();
			begin
				wait (cyc == 60000);
				n_mismatch++;
			end
		join_any
		end_sim();
	end
endmodule : testbench
